// *** src/fbpd_pkg.sv ***
// Package: layout and constants of the basic capability descriptor
package fbpd_pkg;
	localparam int unsigned TABLE_DWORDS      = 23;
	localparam int unsigned DWORD_W           = 32;
	localparam int unsigned ADDR_W            = 24;
	localparam int unsigned IDX_W             = 5;
	// Word numbers (1-based) of words with fixed meaning
	localparam int unsigned WORD_CAPS         = 1;
	localparam int unsigned WORD_ERASE_12     = 8;
	localparam int unsigned WORD_ERASE_34     = 9;
	localparam int unsigned WORD_SPEED        = 20;
	// Field positions in word one
	localparam int unsigned POS_UNUSED_HI_LSB = 23;
	localparam int unsigned POS_QUAD_OUT      = 22;
	localparam int unsigned POS_QUAD_IO       = 21;
	localparam int unsigned POS_DUAL_IO       = 20;
	localparam int unsigned POS_DTR           = 19;
	localparam int unsigned POS_ADDR_LSB      = 17;
	localparam int unsigned POS_DUAL_OUT      = 16;
	localparam int unsigned POS_ERASE4K_LSB   = 8;
	localparam int unsigned POS_UNUSED_LO_LSB = 5;
	// Fixed field values
	localparam logic [8:0]  UNUSED_HI_VAL     = 9'h1ff;
	localparam logic [2:0]  UNUSED_LO_VAL     = 3'h7;
	localparam logic [7:0]  NO_ERASE4K_OP     = 8'hff;
	localparam logic [31:0] UNDEF_WORD        = 32'hffffffff;
	// Address size field encodings
	localparam logic [1:0]  ADDR_3B_ONLY      = 2'h0;
	localparam logic [1:0]  ADDR_3B_OR_4B     = 2'h1;
	localparam logic [1:0]  ADDR_4B_ONLY      = 2'h2;
	localparam logic [1:0]  ADDR_RESERVED     = 2'h3;
	// Opcodes and timing
	localparam logic [7:0]  OP_BASIC_READ     = 8'h03;
	localparam logic [3:0]  DUAL_OUT_WAIT     = 4'h8;
	localparam int unsigned RD_LATENCY        = 1;
	// Erase type word layout: size byte then opcode byte, two per word
	localparam int unsigned ERASE_SLOT_W      = 16;
	localparam int unsigned ERASE_OP_LSB      = 8;

	typedef enum logic {
		FBPD_AM_3B,
		FBPD_AM_4B
	} fbpd_amode_e;
endpackage : fbpd_pkg

// *** src/fbpd_addr_mode.sv ***
// Address byte count tracker for array and descriptor commands
`timescale 1ns/10ps
module fbpd_addr_mode #(
	parameter logic [1:0] P_ADDR_BYTES = fbpd_pkg::ADDR_3B_ONLY
) (
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_enter_4b,
	input  wire logic       i_exit_4b,
	input  wire logic [7:0] i_cmd_opcode,
	input  wire logic       i_cmd_discovery,
	output logic            o_mode_4b,
	output logic            o_cmd_addr_4b
);
	import fbpd_pkg::*;

	fbpd_amode_e mode_r;
	fbpd_amode_e mode_nxt;

	always_comb begin
		mode_nxt = mode_r;
		case (P_ADDR_BYTES)
			ADDR_3B_OR_4B: begin
				if (i_enter_4b) begin
					mode_nxt = FBPD_AM_4B;
				end else if (i_exit_4b) begin
					mode_nxt = FBPD_AM_3B;
				end
			end
			ADDR_4B_ONLY: mode_nxt = FBPD_AM_4B;
			default:      mode_nxt = FBPD_AM_3B;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_r <= FBPD_AM_3B;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign o_mode_4b = (mode_r == FBPD_AM_4B);

	always_comb begin
		if (i_cmd_discovery) begin
			o_cmd_addr_4b = 1'b0;
		end else if (P_ADDR_BYTES == ADDR_4B_ONLY &&
				i_cmd_opcode == OP_BASIC_READ) begin
			o_cmd_addr_4b = 1'b0;
		end else begin
			o_cmd_addr_4b = o_mode_4b;
		end
	end
endmodule : fbpd_addr_mode

// *** src/fbpd_param_table.sv ***
// Basic capability descriptor table with word read port and address mode
`timescale 1ns/10ps
module fbpd_param_table #(
	parameter int unsigned P_TABLE_DWORDS = fbpd_pkg::TABLE_DWORDS,
	parameter logic [23:0] P_TABLE_PTR    = 24'h000080,
	parameter logic        P_QUAD_OUT     = 1'b1,
	parameter logic        P_QUAD_IO      = 1'b1,
	parameter logic        P_DUAL_IO      = 1'b1,
	parameter logic        P_DTR          = 1'b0,
	parameter logic [1:0]  P_ADDR_BYTES   = fbpd_pkg::ADDR_3B_OR_4B,
	parameter logic        P_DUAL_OUT     = 1'b1,
	parameter logic [7:0]  P_ERASE4K_OP   = 8'h20,
	parameter logic [4:0]  P_LEGACY_LO    = 5'h05,
	parameter logic [7:0]  P_ER1_SIZE     = 8'h0c,
	parameter logic [7:0]  P_ER1_OP       = 8'h20,
	parameter logic [7:0]  P_ER2_SIZE     = 8'h0f,
	parameter logic [7:0]  P_ER2_OP       = 8'h52,
	parameter logic [7:0]  P_ER3_SIZE     = 8'h10,
	parameter logic [7:0]  P_ER3_OP       = 8'hd8,
	parameter logic [7:0]  P_ER4_SIZE     = 8'h00,
	parameter logic [7:0]  P_ER4_OP       = 8'hff,
	parameter logic [31:0] P_SPEED_WORD   = 32'hffffffff,
	parameter logic [31:0] P_DENSITY_WORD = 32'h00ffffff,
	parameter logic [31:0] P_OTHER_WORD   = 32'hffffffff
) (
	input  wire logic                         i_clk,
	input  wire logic                         i_resetn,
	input  wire logic                         i_rd_req,
	input  wire logic [fbpd_pkg::ADDR_W-1:0]  i_rd_addr,
	output logic                              o_rd_valid,
	output logic      [fbpd_pkg::DWORD_W-1:0] o_rd_data,
	output logic                              o_rd_hit,
	input  wire logic                         i_enter_4b,
	input  wire logic                         i_exit_4b,
	input  wire logic [7:0]                   i_cmd_opcode,
	input  wire logic                         i_cmd_discovery,
	output logic                              o_mode_4b,
	output logic                              o_cmd_addr_4b,
	output logic      [3:0]                   o_dual_out_wait
);
	import fbpd_pkg::*;

	// Byte address just past the last table word
	localparam logic [31:0] TABLE_END = 32'(P_TABLE_PTR) +
		32'(TABLE_DWORDS) * 32'h4;

	// Elaboration checks on the descriptor contents
	if (P_TABLE_DWORDS != TABLE_DWORDS) begin : g_bad_len
		$error("Table length must be 23 double-words");
	end
	if (P_ADDR_BYTES == ADDR_RESERVED) begin : g_bad_addr
		$error("Address size code 11b is reserved");
	end
	if (P_ERASE4K_OP != NO_ERASE4K_OP && P_ERASE4K_OP != P_ER1_OP &&
			P_ERASE4K_OP != P_ER2_OP && P_ERASE4K_OP != P_ER3_OP &&
			P_ERASE4K_OP != P_ER4_OP) begin : g_bad_erase
		$error("4 KB erase opcode missing from erase types");
	end

	// Table placement inside the three-byte descriptor space
	if (P_TABLE_PTR[1:0] != 2'h0) begin : g_bad_align
		$error("Table pointer must be double-word aligned");
	end
	if (TABLE_END > 32'h01000000) begin : g_bad_span
		$error("Table must end inside the three-byte space");
	end

	// Index width and fixed word numbers against the table length
	if (TABLE_DWORDS > (1 << IDX_W)) begin : g_bad_idx
		$error("Word index too narrow for the table");
	end
	if (WORD_SPEED > TABLE_DWORDS ||
			WORD_ERASE_34 > TABLE_DWORDS) begin : g_bad_map
		$error("Fixed word numbers lie outside the table");
	end

	// Density word: the power-of-two form needs an exponent of 32 or more
	if (P_DENSITY_WORD[31] && P_DENSITY_WORD[30:0] < 31'h20) begin : g_bad_den
		$error("Density exponent below 32");
	end

	logic [DWORD_W-1:0] word_one;
	logic [DWORD_W-1:0] table_mem [TABLE_DWORDS];
	// Erase type words
	logic [DWORD_W-1:0] erase_12;
	logic [DWORD_W-1:0] erase_34;

	// Word one assembled from fixed fields and capability settings
	always_comb begin
		word_one = '0;
		word_one[31:POS_UNUSED_HI_LSB]     = UNUSED_HI_VAL;
		word_one[POS_QUAD_OUT]             = P_QUAD_OUT;
		word_one[POS_QUAD_IO]              = P_QUAD_IO;
		word_one[POS_DUAL_IO]              = P_DUAL_IO;
		word_one[POS_DTR]                  = P_DTR;
		word_one[POS_ADDR_LSB +: 2]        = P_ADDR_BYTES;
		word_one[POS_DUAL_OUT]             = P_DUAL_OUT;
		word_one[POS_ERASE4K_LSB +: 8]     = P_ERASE4K_OP;
		word_one[POS_UNUSED_LO_LSB +: 3]   = UNUSED_LO_VAL;
		word_one[4:0]                      = P_LEGACY_LO;
	end

	// Erase types one and two: size byte below opcode byte
	always_comb begin
		erase_12                                   = '0;
		erase_12[0 +: 8]                           = P_ER1_SIZE;
		erase_12[ERASE_OP_LSB +: 8]                = P_ER1_OP;
		erase_12[ERASE_SLOT_W +: 8]                = P_ER2_SIZE;
		erase_12[ERASE_SLOT_W + ERASE_OP_LSB +: 8] = P_ER2_OP;
	end

	// Erase types three and four: size byte below opcode byte
	always_comb begin
		erase_34                                   = '0;
		erase_34[0 +: 8]                           = P_ER3_SIZE;
		erase_34[ERASE_OP_LSB +: 8]                = P_ER3_OP;
		erase_34[ERASE_SLOT_W +: 8]                = P_ER4_SIZE;
		erase_34[ERASE_SLOT_W + ERASE_OP_LSB +: 8] = P_ER4_OP;
	end

	// Table contents, words numbered from one
	// Words without modelled contents read as the filler word
	always_comb begin
		for (int i = 0; i < TABLE_DWORDS; i++) begin
			table_mem[i] = P_OTHER_WORD;
		end
		table_mem[WORD_CAPS-1]     = word_one;
		table_mem[1]               = P_DENSITY_WORD;
		table_mem[WORD_ERASE_12-1] = erase_12;
		table_mem[WORD_ERASE_34-1] = erase_34;
		table_mem[WORD_SPEED-1]    = P_SPEED_WORD;
	end

	// Read decode: three-byte address relative to the table pointer
	logic [ADDR_W-1:0] rel_addr;
	logic [ADDR_W-3:0] rel_idx;
	logic [IDX_W-1:0]  rd_word;
	logic              above_base;
	logic              below_end;
	logic              in_range;

	assign rel_addr   = i_rd_addr - P_TABLE_PTR;
	assign rel_idx    = rel_addr[ADDR_W-1:2];
	assign rd_word    = rel_idx[IDX_W-1:0];
	assign above_base = (i_rd_addr >= P_TABLE_PTR);
	assign below_end  = (rel_idx < (ADDR_W-2)'(TABLE_DWORDS));
	assign in_range   = above_base && below_end;

	// Read data: a word outside the table reads as all ones
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_data <= UNDEF_WORD;
		end else if (i_rd_req) begin
			if (in_range) begin
				o_rd_data <= table_mem[rd_word];
			end else begin
				o_rd_data <= UNDEF_WORD;
			end
		end
	end

	// Hit flag of the last read
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_hit <= 1'b0;
		end else if (i_rd_req) begin
			o_rd_hit <= in_range;
		end
	end

	// Valid follows each request by one cycle
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_req;
		end
	end

	// Wait states of the dual-output read
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_dual_out_wait <= DUAL_OUT_WAIT;
		end else begin
			o_dual_out_wait <= P_DUAL_OUT ? DUAL_OUT_WAIT : 4'h0;
		end
	end

	// Address byte count for the current command
	fbpd_addr_mode #(
		.P_ADDR_BYTES (P_ADDR_BYTES)
	) u_addr_mode (
		.i_clk           (i_clk),
		.i_resetn        (i_resetn),
		.i_enter_4b      (i_enter_4b),
		.i_exit_4b       (i_exit_4b),
		.i_cmd_opcode    (i_cmd_opcode),
		.i_cmd_discovery (i_cmd_discovery),
		.o_mode_4b       (o_mode_4b),
		.o_cmd_addr_4b   (o_cmd_addr_4b)
	);
endmodule : fbpd_param_table

// *** tb/fbpd_props.sv ***
// Checker of read port and address mode timing
`timescale 1ns/10ps
module fbpd_props import fbpd_pkg::*; #(
	parameter logic [23:0] P_TABLE_PTR  = 24'h000080,
	parameter logic [1:0]  P_ADDR_BYTES = 2'h1,
	parameter logic        P_DUAL_OUT   = 1'b1
) (
	input  wire logic                         i_clk,
	input  wire logic                         i_resetn,
	input  wire logic                         i_rd_req,
	input  wire logic [fbpd_pkg::ADDR_W-1:0]  i_rd_addr,
	input  wire logic                         o_rd_valid,
	input  wire logic [fbpd_pkg::DWORD_W-1:0] o_rd_data,
	input  wire logic                         o_rd_hit,
	input  wire logic                         i_enter_4b,
	input  wire logic                         i_exit_4b,
	input  wire logic                         i_cmd_discovery,
	input  wire logic                         o_mode_4b,
	input  wire logic                         o_cmd_addr_4b,
	input  wire logic [3:0]                   o_dual_out_wait
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_w1_req;
		i_rd_req && i_rd_addr[23:2] == P_TABLE_PTR[23:2];
	endsequence
	sequence s_fixed;
		o_rd_hit && o_rd_data[31:23] == UNUSED_HI_VAL
			&& o_rd_data[7:5] == UNUSED_LO_VAL;
	endsequence
	property p_fixed; s_w1_req |=> s_fixed; endproperty
	property p_miss; i_rd_req && (i_rd_addr < P_TABLE_PTR || i_rd_addr >=
		P_TABLE_PTR + 24'(TABLE_DWORDS * 4)) |=> !o_rd_hit
		&& o_rd_data == UNDEF_WORD; endproperty
	property p_valid; i_rd_req |=> o_rd_valid; endproperty
	property p_idle; !i_rd_req |=> !o_rd_valid && $stable(o_rd_data); endproperty
	property p_enter; i_enter_4b && P_ADDR_BYTES == ADDR_3B_OR_4B |=> o_mode_4b;
	endproperty
	property p_exit; i_exit_4b && !i_enter_4b &&
		P_ADDR_BYTES == ADDR_3B_OR_4B |=> !o_mode_4b; endproperty
	property p_hold; !i_enter_4b && !i_exit_4b &&
		P_ADDR_BYTES != ADDR_4B_ONLY |=> $stable(o_mode_4b); endproperty
	property p_only4; P_ADDR_BYTES == ADDR_4B_ONLY |=> o_mode_4b;
	endproperty
	property p_disc; i_cmd_discovery |-> !o_cmd_addr_4b; endproperty
	property p_wait; o_rd_valid |->
		o_dual_out_wait == (P_DUAL_OUT ? DUAL_OUT_WAIT : 4'h0); endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed bits wrong");
	a_miss: assert property (p_miss)
		else $error("miss not refused");
	a_valid: assert property (p_valid) else $error("no valid");
	a_idle: assert property (p_idle) else $error("spurious read");
	a_enter: assert property (p_enter)
		else $error("enter ignored");
	a_exit: assert property (p_exit)
		else $error("exit ignored");
	a_hold: assert property (p_hold)
		else $error("mode changed alone");
	a_only4: assert property (p_only4)
		else $error("four byte only part not in four byte mode");
	a_disc: assert property (p_disc)
		else $error("descriptor not 3 byte");
	a_wait: assert property (p_wait)
		else $error("wait count wrong");
endmodule : fbpd_props
bind fbpd_param_table fbpd_props #(.P_TABLE_PTR(P_TABLE_PTR),
	.P_ADDR_BYTES(P_ADDR_BYTES), .P_DUAL_OUT(P_DUAL_OUT)) i_fbpd_props (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_rd_req(i_rd_req),
	.i_rd_addr(i_rd_addr), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
	.o_rd_hit(o_rd_hit), .i_enter_4b(i_enter_4b), .i_exit_4b(i_exit_4b),
	.i_cmd_discovery(i_cmd_discovery), .o_mode_4b(o_mode_4b),
	.o_cmd_addr_4b(o_cmd_addr_4b), .o_dual_out_wait(o_dual_out_wait));

// *** tb/fbpd_host.sv ***
// Host decoder model of capability word one
`timescale 1ns/10ps
module fbpd_host import fbpd_pkg::*; (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_take,
	input  wire logic [31:0] i_word,
	output logic             o_desc_ok,
	output logic             o_addr4_ok
);
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_desc_ok  <= 1'b0;
			o_addr4_ok <= 1'b0;
		end else if (i_take) begin
			o_desc_ok  <= i_word[18:17] != ADDR_RESERVED;
			o_addr4_ok <= i_word[18:17] == ADDR_3B_OR_4B
				|| i_word[18:17] == ADDR_4B_ONLY;
		end
	end
endmodule : fbpd_host

// *** tb/tb_top.sv ***
// Testbench of the capability descriptor table
`timescale 1ns/10ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin \
	err_total++; $display("BAD %0t %s", $time, m); end end
module tb_top import fbpd_pkg::*;;
	localparam logic [31:0] W1 = {UNUSED_HI_VAL, 3'h7, 1'b0, ADDR_3B_OR_4B,
		1'b1, 8'h20, UNUSED_LO_VAL, 5'h05};
	localparam logic [31:0] W1B = {UNUSED_HI_VAL, 3'h7, 1'b1, ADDR_4B_ONLY,
		1'b0, NO_ERASE4K_OP, UNUSED_LO_VAL, 5'h05};
	logic        b_valid, b_hit, b_m4, b_a4;
	logic [31:0] b_data;
	logic [3:0]  b_wait;
	logic clk, resetn, rd_req, rd_valid, rd_hit, ent, ext, disc, m4, a4, w1;
	logic h_ok, h_a4;
	logic [23:0] rd_addr;
	logic [31:0] rd_data;
	logic [7:0]  opc;
	logic [3:0]  dwait;
	int          err_total, samples_checked;
	fbpd_param_table i_fbpd_param_table (.i_clk(clk), .i_resetn(resetn),
		.i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_rd_hit(rd_hit), .i_enter_4b(ent),
		.i_exit_4b(ext), .i_cmd_opcode(opc), .i_cmd_discovery(disc),
		.o_mode_4b(m4), .o_cmd_addr_4b(a4), .o_dual_out_wait(dwait));
	fbpd_param_table #(.P_DTR(1'b1), .P_ADDR_BYTES(ADDR_4B_ONLY),
		.P_DUAL_OUT(1'b0), .P_ERASE4K_OP(NO_ERASE4K_OP))
		i_fbpd_param_table_b (.i_clk(clk), .i_resetn(resetn),
		.i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_valid(b_valid),
		.o_rd_data(b_data), .o_rd_hit(b_hit), .i_enter_4b(ent),
		.i_exit_4b(ext), .i_cmd_opcode(opc), .i_cmd_discovery(disc),
		.o_mode_4b(b_m4), .o_cmd_addr_4b(b_a4), .o_dual_out_wait(b_wait));
	fbpd_host i_fbpd_host (.i_clk(clk), .i_resetn(resetn),
		.i_take(rd_valid & w1), .i_word(rd_data), .o_desc_ok(h_ok),
		.o_addr4_ok(h_a4));
	task complete_run;
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	task rd(input logic [23:0] a, input logic [31:0] e, input logic h);
		@(negedge clk);
		rd_req = 1'b1;
		rd_addr = a;
		@(negedge clk);
		rd_req = 1'b0;
		`CHK(rd_valid, 1'b1, "valid")
		`CHK(rd_data, e, "data")
		`CHK(rd_hit, h, "hit")
	endtask : rd
	task cmd(input logic en, ex, d, m, c);
		@(negedge clk);
		ent = en;
		ext = ex;
		disc = d;
		@(negedge clk);
		ent = 1'b0;
		ext = 1'b0;
		`CHK(m4, m, "mode")
		`CHK(a4, c, "addr bytes")
	endtask : cmd
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#20000;
		err_total++;
		complete_run;
	end
	initial begin
		{resetn, rd_req, ent, ext, disc, w1} = '0;
		rd_addr = 24'h000000;
		opc = 8'h0b;
		repeat (4) @(posedge clk);
		@(negedge clk) resetn = 1'b1;
		`CHK(m4, 1'b0, "reset mode")
		`CHK(dwait, DUAL_OUT_WAIT, "wait")
		`CHK(b_m4, 1'b0, "reset mode b")
		w1 = 1'b1;
		rd(24'h000080, W1, 1'b1);
		`CHK(b_data, W1B, "word one b")
		`CHK(b_valid, 1'b1, "valid b")
		`CHK(b_hit, 1'b1, "hit b")
		`CHK(b_m4, 1'b1, "four byte only mode")
		`CHK(b_wait, 4'h0, "no dual wait")
		rd(24'h000083, W1, 1'b1);
		@(negedge clk) w1 = 1'b0;
		`CHK(h_ok, 1'b1, "descriptor")
		`CHK(h_a4, 1'b1, "four byte")
		rd(24'h000084, 32'h00ffffff, 1'b1);
		rd(24'h00009c, 32'h520f200c, 1'b1);
		rd(24'h0000a0, 32'hff00d810, 1'b1);
		rd(24'h0000cc, 32'hffffffff, 1'b1);
		rd(24'h0000d8, 32'hffffffff, 1'b1);
		rd(24'h0000dc, UNDEF_WORD, 1'b0);
		rd(24'h00007c, UNDEF_WORD, 1'b0);
		@(negedge clk) rd_req = 1'b1;
		rd_addr = 24'h000080;
		@(negedge clk) rd_addr = 24'h00009c;
		@(negedge clk) rd_req = 1'b0;
		`CHK(rd_data, 32'h520f200c, "back to back")
		cmd(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		cmd(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		`CHK(b_a4, 1'b1, "four byte only array")
		cmd(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		`CHK(b_a4, 1'b0, "descriptor b")
		cmd(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		cmd(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		@(negedge clk) opc = OP_BASIC_READ;
		@(negedge clk);
		`CHK(b_a4, 1'b0, "basic read three byte")
		`CHK(a4, 1'b1, "basic read in four byte mode")
		complete_run;
	end
endmodule : tb_top
